// ==== pscr_defines.svh ====
`ifndef PSCR_DEFINES_SVH
`define PSCR_DEFINES_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define PSCR_CLK_PERIOD_NS 20
`define PSCR_FILT_CYC 3
`define PSCR_T_ACTIVE_NS 2000
`define PSCR_T_REFRESH_NS 20000
`define PSCR_ACTIVE_CYC ((`PSCR_T_ACTIVE_NS + `PSCR_CLK_PERIOD_NS - 1) / `PSCR_CLK_PERIOD_NS)
`define PSCR_REFRESH_CYC ((`PSCR_T_REFRESH_NS + `PSCR_CLK_PERIOD_NS - 1) / `PSCR_CLK_PERIOD_NS)

// ****************************************************************
// sizes and reset values
// ****************************************************************
`define PSCR_CH_NUM 2
`define PSCR_LVL_NUM 7
`define PSCR_FAULT_RST 1'b1
`define PSCR_REG_RESET_RST 1'b1
`define PSCR_LEVEL_RST 1'b0

`endif

// ==== pscr_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// host side: soft reset bit and fault flag read
// ****************************************************************
module pscr_host_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic spi_write_en,
   input wire logic reg_reset,
   input wire logic sr_req,
   input wire logic clr_req,
   output logic soft_reset_cmd_bit,
   output logic fault_flag_clear
);
   // host sets bit, bank reset or write disable clears it
   always_ff @(negedge clk or posedge reset) begin
      if (reset) begin
         soft_reset_cmd_bit <= 1'b0;
      end else if (sr_req) begin
         soft_reset_cmd_bit <= 1'b1;
      end else if (reg_reset || !spi_write_en) begin
         soft_reset_cmd_bit <= 1'b0;
      end
   end

   // flag read clears it, one cycle
   always_ff @(negedge clk or posedge reset) begin
      if (reset) begin
         fault_flag_clear <= 1'b0;
      end else begin
         fault_flag_clear <= clr_req;
      end
   end
endmodule : pscr_host_model

`default_nettype wire

// ==== pscr_level_filter.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pscr_defines.svh"

module pscr_level_filter #(
   parameter int unsigned FILT_CYC = `PSCR_FILT_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic level_in,
   output logic level_out
);

   localparam int unsigned CW = $clog2(FILT_CYC + 1);

   logic [CW-1:0] cnt;

   // ****************************************************************
   // stability filter
   // ****************************************************************
   // settle before use
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt <= '0;
         level_out <= `PSCR_LEVEL_RST;
      end else if (level_in == level_out) begin
         cnt <= '0;
      end else if (cnt == CW'(FILT_CYC - 1)) begin
         level_out <= level_in;
         cnt <= '0;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   a_filter_settle: assert property (@(posedge clk) disable iff (reset)
      $changed(level_out) |-> ($past(level_in, 1) == level_out) && ($past(level_in, 2) == level_out)
         && ($past(level_in, 3) == level_out))
      else $error("filter output moved before input was stable");

   a_filter_bound: assert property (@(posedge clk) disable iff (reset)
      (level_in == $past(level_in, 1)) && (level_in == $past(level_in, 2)) && (level_in == $past(level_in, 3))
         |-> level_out == level_in)
      else $error("filter output late after stable input");

endmodule : pscr_level_filter
`default_nettype wire

// ==== pscr_pkg.sv ====
package pscr_pkg;

   // ****************************************************************
   // power states
   // ****************************************************************
   typedef enum logic [3:0] {
      st_sleep = 4'h1,
      st_idle = 4'h2,
      st_limp = 4'h4,
      st_active = 4'h8
   } pscr_state_t;

   // ****************************************************************
   // monitored levels, high means present or set
   // ****************************************************************
   typedef struct packed {
      logic vin_ok;
      logic enable_uvlo_pin;
      logic internal_ldo_out;
      logic driver_supply;
      logic vdd_ok;
      logic backup_control_input;
      logic low_power_hold_bit;
   } pscr_levels_t;

endpackage : pscr_pkg

// ==== pscr_power_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pscr_defines.svh"

module pscr_power_ctrl #(
   parameter int unsigned CH_NUM = `PSCR_CH_NUM,
   parameter int unsigned FILT_CYC = `PSCR_FILT_CYC,
   parameter int unsigned ACTIVE_CYC = `PSCR_ACTIVE_CYC,
   parameter int unsigned REFRESH_CYC = `PSCR_REFRESH_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire pscr_pkg::pscr_levels_t mon_raw,
   input wire logic [CH_NUM-1:0] dim_pwm_input,
   input wire logic [CH_NUM-1:0] dim_pwm_bit,
   input wire logic [CH_NUM-1:0] loop_control_reg,
   input wire logic [CH_NUM-1:0] bst_ok,
   input wire logic soft_reset_cmd_bit,
   input wire logic fault_flag_clear,
   output var pscr_pkg::pscr_state_t power_state,
   output logic reg_reset,
   output logic calib_reset,
   output logic spi_read_en,
   output logic spi_write_en,
   output logic ldo_enable,
   output logic [CH_NUM-1:0] switch_en,
   output logic [CH_NUM-1:0] high_side_driver,
   output logic [CH_NUM-1:0] bootstrap_refresh,
   output logic [CH_NUM-1:0] calib_read_en,
   output logic transmission_fault_flag
);

   import pscr_pkg::*;

   localparam int unsigned LVL_NUM = `PSCR_LVL_NUM;
   localparam int unsigned AW = $clog2(ACTIVE_CYC + 1);
   localparam int unsigned RW = $clog2(REFRESH_CYC + 1);

   logic [LVL_NUM-1:0] raw_vec;
   logic [LVL_NUM-1:0] filt_vec;
   pscr_levels_t f;
   pscr_state_t next_state;
   logic [AW-1:0] wake_cnt;
   logic wake_done;
   logic limp_entry;
   logic hw_rst;
   logic soft_rst;
   logic drv_ok;
   logic next_read;
   logic next_write;
   logic [CH_NUM-1:0] run_req;
   logic [CH_NUM-1:0] dim_on;
   logic [CH_NUM-1:0] refresh_pulse;

   // ****************************************************************
   // level filters
   // ****************************************************************
   assign raw_vec = mon_raw;
   assign f = pscr_levels_t'(filt_vec);

   genvar gi;
   generate
      for (gi = 0; gi < LVL_NUM; gi++) begin : g_filt
         pscr_level_filter #(
            .FILT_CYC(FILT_CYC)
         ) u_filt (
            .clk(clk),
            .reset(reset),
            .level_in(raw_vec[gi]),
            .level_out(filt_vec[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // activation timer
   // ****************************************************************
   assign wake_done = (wake_cnt == AW'(ACTIVE_CYC));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wake_cnt <= '0;
      end else if (power_state != st_sleep || !f.enable_uvlo_pin) begin
         wake_cnt <= '0;
      end else if (!wake_done) begin
         wake_cnt <= wake_cnt + 1'b1;
      end
   end

   // ****************************************************************
   // state selection
   // ****************************************************************
   always_comb begin
      next_state = power_state;
      if (!f.enable_uvlo_pin) begin
         next_state = st_sleep;
      end else begin
         case (power_state)
            st_sleep: begin
               if (f.backup_control_input) begin
                  next_state = st_limp;
               end else if (f.low_power_hold_bit) begin
                  next_state = st_idle;
               end else if (wake_done) begin
                  next_state = st_active;
               end
            end
            st_idle: begin
               if (f.backup_control_input) begin
                  next_state = st_limp;
               end else if (!f.low_power_hold_bit) begin
                  next_state = st_active;
               end
            end
            st_active: begin
               if (f.backup_control_input) begin
                  next_state = st_limp;
               end else if (f.low_power_hold_bit) begin
                  next_state = st_idle;
               end
            end
            st_limp: begin
               if (!f.backup_control_input) begin
                  next_state = f.low_power_hold_bit ? st_idle : st_active;
               end
            end
            default: begin
               next_state = st_sleep;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         power_state <= st_sleep;
      end else begin
         power_state <= next_state;
      end
   end

   // ****************************************************************
   // reset sources and access gating
   // ****************************************************************
   assign limp_entry = (next_state == st_limp) && (power_state != st_limp);
   assign hw_rst = !f.vdd_ok || !f.enable_uvlo_pin || (next_state == st_sleep) || limp_entry;
   assign soft_rst = soft_reset_cmd_bit && spi_write_en;
   assign next_read = f.vdd_ok && f.enable_uvlo_pin && (next_state != st_sleep);
   assign next_write = next_read && ((next_state == st_idle) || (next_state == st_active));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_reset <= `PSCR_REG_RESET_RST;
         calib_reset <= `PSCR_REG_RESET_RST;
      end else begin
         reg_reset <= hw_rst || soft_rst;
         calib_reset <= hw_rst;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         spi_read_en <= 1'b0;
         spi_write_en <= 1'b0;
         calib_read_en <= '0;
      end else begin
         spi_read_en <= next_read;
         spi_write_en <= next_write;
         calib_read_en <= next_read ? loop_control_reg : '0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         transmission_fault_flag <= `PSCR_FAULT_RST;
      end else if (reg_reset) begin
         transmission_fault_flag <= 1'b1;
      end else if (fault_flag_clear) begin
         transmission_fault_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ldo_enable <= 1'b0;
      end else begin
         ldo_enable <= f.enable_uvlo_pin && (next_state != st_sleep);
      end
   end

   // ****************************************************************
   // channel drive
   // ****************************************************************
   // logic, driver and LDO supplies gate drivers
   assign drv_ok = f.vdd_ok && f.driver_supply && f.internal_ldo_out;
   assign dim_on = dim_pwm_input | dim_pwm_bit;

   generate
      for (gi = 0; gi < CH_NUM; gi++) begin : g_ch
         logic [RW-1:0] refresh_cnt;

         assign run_req[gi] = ((next_state == st_active) && dim_on[gi])
            || ((next_state == st_limp) && f.vin_ok);

         assign refresh_pulse[gi] = (refresh_cnt == RW'(REFRESH_CYC - 1)) && (next_state == st_active)
            && !dim_on[gi] && drv_ok;

         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               refresh_cnt <= '0;
            end else if (next_state != st_active || dim_on[gi] || !drv_ok || refresh_pulse[gi]) begin
               refresh_cnt <= '0;
            end else begin
               refresh_cnt <= refresh_cnt + 1'b1;
            end
         end

         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               switch_en[gi] <= 1'b0;
               high_side_driver[gi] <= 1'b0;
               bootstrap_refresh[gi] <= 1'b0;
            end else begin
               switch_en[gi] <= drv_ok && run_req[gi];
               high_side_driver[gi] <= drv_ok && run_req[gi] && bst_ok[gi];
               bootstrap_refresh[gi] <= refresh_pulse[gi];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_vdd_uv_gate: assert property (!f.vdd_ok |=> switch_en == '0 && high_side_driver == '0
      && !spi_read_en && reg_reset)
      else $error("logic supply low but drive or access still on");

   a_drv_uv_stop: assert property (!f.driver_supply || !f.internal_ldo_out
      |=> switch_en == '0 && high_side_driver == '0)
      else $error("driver undervoltage did not stop switching");

   a_drv_uv_keep: assert property (f.vdd_ok && f.enable_uvlo_pin && !f.driver_supply
      && next_state == power_state && power_state != st_sleep && !soft_rst |=> !reg_reset)
      else $error("driver undervoltage reset the registers");

   a_en_low_reset: assert property (!f.enable_uvlo_pin |=> !spi_read_en && !ldo_enable
      && reg_reset && switch_en == '0)
      else $error("enable low did not shut down");

   a_en_low_sleep: assert property (!f.enable_uvlo_pin |=> power_state == st_sleep)
      else $error("enable low did not enter sleep");

   a_sleep_reset: assert property (power_state == st_sleep |-> reg_reset && calib_reset
      && switch_en == '0 && !ldo_enable)
      else $error("sleep without bank reset or with outputs on");

   a_wake_time: assert property ($past(power_state == st_sleep) && power_state == st_active
      |-> $past(wake_cnt) == AW'(ACTIVE_CYC))
      else $error("active entered before activation time");

   a_idle_quiet: assert property (power_state == st_idle |-> switch_en == '0
      && high_side_driver == '0 && ldo_enable)
      else $error("switching or regulator off in idle");

   a_idle_spi_rw: assert property (power_state == st_idle && $past(f.vdd_ok)
      |-> spi_read_en && spi_write_en)
      else $error("idle access not granted");

   a_limp_entry: assert property ($rose(power_state == st_limp) |-> reg_reset && calib_reset)
      else $error("limp entry without bank reset");

   a_limp_read_only: assert property (power_state == st_limp
      |-> !spi_write_en && (spi_read_en == $past(f.vdd_ok)))
      else $error("limp access wrong");

   a_limp_supply: assert property (power_state == st_limp && switch_en != '0
      |-> $past(f.vin_ok) && $past(f.driver_supply))
      else $error("limp regulation without supplies");

   a_dim_gate: assert property (power_state == st_active && switch_en[0]
      |-> $past(dim_pwm_input[0] || dim_pwm_bit[0]))
      else $error("active switching without dimming request");

   a_bst_gate: assert property (high_side_driver[0] |-> $past(bst_ok[0]) && switch_en[0])
      else $error("high side started without bootstrap");

   a_refresh_mode: assert property (bootstrap_refresh[0] |-> power_state == st_active
      && !switch_en[0])
      else $error("refresh pulse outside idle dimming");

   a_fault_set: assert property (reg_reset |=> transmission_fault_flag)
      else $error("fault flag not set after reset");

   a_soft_reset: assert property (soft_reset_cmd_bit && spi_write_en |=> reg_reset)
      else $error("soft reset ignored");

   a_calib_keep: assert property (soft_rst && f.vdd_ok && f.enable_uvlo_pin
      && next_state == power_state |=> !calib_reset)
      else $error("soft reset cleared calibration");

   a_hold_select: assert property ((power_state == st_idle || power_state == st_active)
      && f.enable_uvlo_pin && !f.backup_control_input
      |=> power_state == ($past(f.low_power_hold_bit) ? st_idle : st_active))
      else $error("hold bit did not select state");

   a_backup_first: assert property (f.enable_uvlo_pin && f.backup_control_input
      |=> power_state == st_limp)
      else $error("backup input did not select limp");

   c_wake_active: cover property (power_state == st_sleep ##1 power_state == st_active);
   c_limp_entry: cover property ($rose(power_state == st_limp));
   c_soft_reset: cover property (soft_rst ##1 reg_reset && !calib_reset);
   c_refresh: cover property (bootstrap_refresh[0]);

endmodule : pscr_power_ctrl
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import pscr_pkg::*;

   // ****************************************************************
   // stimulus and observed signals
   // ****************************************************************
   logic clk = 1'b0;
   logic reset = 1'b1;
   pscr_levels_t lv = '0;
   logic [1:0] dim_pin = 2'h0;
   logic [1:0] dim_bit = 2'h0;
   logic [1:0] loop_ctl = 2'h0;
   logic [1:0] bst = 2'h0;
   logic sr_req = 1'b0;
   logic clr_req = 1'b0;
   logic soft_bit, flag_clr, rr, cr, spi_rd, spi_wr, ldo, flag;
   pscr_state_t st;
   logic [1:0] sw, hsd, refr, cal_rd;
   int n_fail = 0;
   int checks = 0;
   int cycles = 0;
   int cnt;

   always #10 clk = ~clk;

   pscr_power_ctrl #(.ACTIVE_CYC(4), .REFRESH_CYC(8)) pscr_power_ctrl_inst (
      .clk(clk), .reset(reset), .mon_raw(lv), .dim_pwm_input(dim_pin), .dim_pwm_bit(dim_bit),
      .loop_control_reg(loop_ctl), .bst_ok(bst), .soft_reset_cmd_bit(soft_bit),
      .fault_flag_clear(flag_clr), .power_state(st), .reg_reset(rr), .calib_reset(cr),
      .spi_read_en(spi_rd), .spi_write_en(spi_wr), .ldo_enable(ldo), .switch_en(sw),
      .high_side_driver(hsd), .bootstrap_refresh(refr), .calib_read_en(cal_rd),
      .transmission_fault_flag(flag)
   );

   pscr_host_model pscr_host_model_inst (
      .clk(clk), .reset(reset), .spi_write_en(spi_wr), .reg_reset(rr), .sr_req(sr_req),
      .clr_req(clr_req), .soft_reset_cmd_bit(soft_bit), .fault_flag_clear(flag_clr)
   );

   // ****************************************************************
   // helpers
   // ****************************************************************
   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task count_rr(input int n);
      cnt = 0;
      repeat (n) begin
         cyc(1);
         if (rr === 1'b1) cnt++;
      end
   endtask : count_rr

   task host_pulse(input logic sr);
      @(negedge clk);
      if (sr) begin
         sr_req <= 1'b1;
      end else begin
         clr_req <= 1'b1;
      end
      @(negedge clk);
      sr_req <= 1'b0;
      clr_req <= 1'b0;
   endtask : host_pulse

   task print_verdict;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         print_verdict;
      end
   end

   // ****************************************************************
   // test sequence
   // ****************************************************************
   initial begin
      cyc(5);
      check("state", st, st_sleep);
      check("reg_reset", rr, 1'b1);
      check("fault_flag", flag, 1'b1);
      check("switch_en", sw, 2'h0);
      check("spi_write_en", spi_wr, 1'b0);
      @(negedge clk);
      reset = 1'b0;
      lv = 7'h7C;
      cyc(4);
      check("state_wake", st, st_sleep);
      for (int i = 0; i < 20 && st !== st_active; i++) cyc(1);
      check("state", st, st_active);
      check("ldo_enable", ldo, 1'b1);
      check("spi_write_en", spi_wr, 1'b1);
      check("reg_reset", rr, 1'b0);
      // dimming and bootstrap
      @(negedge clk);
      dim_pin = 2'h1;
      dim_bit = 2'h2;
      bst = 2'h1;
      cyc(3);
      check("switch_en", sw, 2'h3);
      check("high_side", hsd, 2'h1);
      @(negedge clk);
      bst = 2'h3;
      dim_pin = 2'h0;
      cyc(3);
      check("switch_en", sw, 2'h2);
      check("high_side", hsd, 2'h2);
      @(negedge clk);
      dim_bit = 2'h0;
      cnt = 0;
      repeat (40) begin
         cyc(1);
         if (refr !== 2'h0) cnt++;
      end
      check("refresh_seen", cnt > 0, 1'b1);
      check("switch_en", sw, 2'h0);
      // driver supply undervoltage
      @(negedge clk);
      dim_pin = 2'h3;
      lv.driver_supply = 1'b0;
      cyc(5);
      check("switch_en", sw, 2'h0);
      check("reg_reset", rr, 1'b0);
      @(negedge clk);
      lv.driver_supply = 1'b1;
      cyc(5);
      check("switch_en", sw, 2'h3);
      // flag clear, then soft reset
      @(negedge clk);
      loop_ctl = 2'h3;
      host_pulse(1'b0);
      cyc(3);
      check("fault_flag", flag, 1'b0);
      check("calib_read", cal_rd, 2'h3);
      host_pulse(1'b1);
      for (int i = 0; i < 6 && rr !== 1'b1; i++) cyc(1);
      check("reg_reset_soft", rr, 1'b1);
      check("calib_reset", cr, 1'b0);
      cyc(2);
      check("fault_flag", flag, 1'b1);
      check("calib_read", cal_rd, 2'h3);
      // idle
      @(negedge clk);
      lv.low_power_hold_bit = 1'b1;
      cyc(4);
      check("state", st, st_idle);
      check("switch_en", sw, 2'h0);
      check("ldo_enable", ldo, 1'b1);
      check("spi_rw", {spi_rd, spi_wr}, 2'h3);
      // limp home
      @(negedge clk);
      lv.backup_control_input = 1'b1;
      count_rr(8);
      check("limp_reset_cycles", cnt, 8'h01);
      check("state", st, st_limp);
      check("spi_rw", {spi_rd, spi_wr}, 2'h2);
      check("switch_en", sw, 2'h3);
      host_pulse(1'b1);
      count_rr(6);
      check("limp_soft_reset", cnt, 8'h00);
      @(negedge clk);
      lv.vin_ok = 1'b0;
      cyc(5);
      check("switch_en", sw, 2'h0);
      // logic supply loss
      @(negedge clk);
      lv.vdd_ok = 1'b0;
      cyc(5);
      check("reg_reset", rr, 1'b1);
      check("spi_read_en", spi_rd, 1'b0);
      check("high_side", hsd, 2'h0);
      @(negedge clk);
      lv = 7'h7C;
      cyc(6);
      check("state", st, st_active);
      // short enable glitch, then enable loss
      @(negedge clk);
      lv.enable_uvlo_pin = 1'b0;
      repeat (2) @(negedge clk);
      lv.enable_uvlo_pin = 1'b1;
      cyc(6);
      check("state_glitch", st, st_active);
      host_pulse(1'b0);
      cyc(3);
      check("fault_flag", flag, 1'b0);
      @(negedge clk);
      lv.enable_uvlo_pin = 1'b0;
      cyc(4);
      check("state", st, st_sleep);
      check("ldo_enable", ldo, 1'b0);
      check("spi_rw", {spi_rd, spi_wr}, 2'h0);
      check("switch_en", sw, 2'h0);
      check("reg_reset", rr, 1'b1);
      cyc(2);
      check("fault_flag", flag, 1'b1);
      print_verdict;
   end
endmodule : testbench

`default_nettype wire
